// >>> sesoc_pkg.sv
// Constants and types for the serial memory select and output control
// ==================================================================
// Behaviour
// - Select low means selected, traffic accepted
// - Select high deselects, standby, abandons partial command
// - Started program cycle always runs to completion
// - Select rise mid-cycle enters standby after cycle
// - Deselected output driver goes high impedance
// - Select rise after valid write launches cycle
// - Output bit changes only after falling clock
// - Internal write cycle ends within five milliseconds
// - Input bits captured on rising clock edge
// - All bytes travel most significant bit first
// - Pause low forces output high impedance anytime
package sesoc_pkg;

  // ==================================================================
  // Widths
  localparam int BYTE_W = 8;
  localparam int BIT_CNT_W = 3;
  localparam logic [BIT_CNT_W-1:0] BIT_LAST = 3'h7;
  localparam logic [BIT_CNT_W-1:0] BIT_FIRST = 3'h0;
  localparam int FIFO_DEPTH = 16;
  localparam int SYNC_STAGES = 2;
  localparam logic [BYTE_W-1:0] TX_IDLE_WORD = 8'hff;

  // ==================================================================
  // Timing
  localparam int CLK_HZ = 125000000;
  localparam int WR_TIME_MS = 5;
  // Longest time, so the division rounds down
  localparam int WR_CYCLES = WR_TIME_MS * (CLK_HZ / 1000);
  localparam int TIMER_W = 20;

  // ==================================================================
  // States
  typedef enum logic [1:0] {
    SESOC_STANDBY,
    SESOC_ACTIVE,
    SESOC_PROGRAM
  } sesoc_state_t;

endpackage

// >>> sesoc_stream_if.sv
// Valid/ready word stream between the block's own modules
`timescale 1ns/100ps
interface sesoc_stream_if #(parameter int W = 8);
  logic [W-1:0] data;
  logic valid;
  logic ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface

// >>> sesoc_sync.sv
// Two-stage level synchroniser, one per bit
`timescale 1ns/100ps
module sesoc_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Data
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  // ==================================================================
  // Stages
  genvar g;
  generate
    for (g = 0; g < W; g++)
    begin : g_bit
      logic [sesoc_pkg::SYNC_STAGES-1:0] stage;
      always_ff @(posedge clk_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
          stage <= '0;
        else
          stage <= {stage[sesoc_pkg::SYNC_STAGES-2:0], d_i[g]};
      end
      assign q_o[g] = stage[sesoc_pkg::SYNC_STAGES-1];
    end
  endgenerate

endmodule

// >>> sesoc_fifo.sv
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps
module sesoc_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Streams
  sesoc_stream_if.snk in_if,
  sesoc_stream_if.src out_if
);

  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic full;
  logic empty;
  logic push;
  logic pop;

  // ==================================================================
  // Flags
  assign empty = (wr_ptr == rd_ptr);
  assign full = (wr_ptr[AW] != rd_ptr[AW]) &&
                (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign in_if.ready = !full;
  assign out_if.valid = !empty;
  assign out_if.data = mem[rd_ptr[AW-1:0]];
  assign push = in_if.valid && !full;
  assign pop = out_if.ready && !empty;

  // ==================================================================
  // Storage
  always_ff @(posedge clk_i)
  begin
    if (push)
      mem[wr_ptr[AW-1:0]] <= in_if.data;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      wr_ptr <= '0;
    else if (push)
      wr_ptr <= wr_ptr + 1'b1;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rd_ptr <= '0;
    else if (pop)
      rd_ptr <= rd_ptr + 1'b1;
  end

endmodule

// >>> sesoc_top.sv
// Select and serial output control of a serial memory slave
`timescale 1ns/100ps
module sesoc_top #(
  parameter int WR_CYCLES = sesoc_pkg::WR_CYCLES
) (
  // System clock and reset
  input wire logic CLK_I,
  input wire logic RST_N_I,
  // Serial link
  input wire logic SCK_I,
  input wire logic CS_N_I,
  input wire logic SI_I,
  input wire logic PAUSE_N_I,
  output logic SO_O,
  output logic SO_OE_O,
  // Received bytes
  output logic [sesoc_pkg::BYTE_W-1:0] RX_DATA_O,
  output logic RX_VALID_O,
  input wire logic RX_READY_I,
  output logic RX_ROOM_O,
  // Bytes to send
  input wire logic [sesoc_pkg::BYTE_W-1:0] TX_DATA_I,
  input wire logic TX_VALID_I,
  output logic TX_READY_O,
  input wire logic OUT_EN_I,
  // Write cycle control
  input wire logic WR_ARM_I,
  output logic WR_START_O,
  output logic BUSY_O,
  output logic STANDBY_O,
  output logic SELECTED_O
);

  localparam int BW = sesoc_pkg::BYTE_W;
  localparam int CW = sesoc_pkg::BIT_CNT_W;
  localparam int TW = sesoc_pkg::TIMER_W;
  localparam logic [TW-1:0] TIMER_LOAD = TW'(WR_CYCLES - 1);

  // ==================================================================
  // Link domain: input shifting on rising serial clock
  logic sck_rst_n;
  logic [CW-1:0] bit_cnt;
  logic [BW-2:0] rx_shift;
  logic [BW-1:0] rx_hold;
  logic byte_end;
  logic byte_tgl;

  // Deselect clears the partial byte at once, even with the clock still
  assign sck_rst_n = RST_N_I & ~CS_N_I;

  always_ff @(posedge SCK_I or negedge sck_rst_n)
  begin
    if (!sck_rst_n)
      bit_cnt <= sesoc_pkg::BIT_FIRST;
    else if (PAUSE_N_I)
      bit_cnt <= bit_cnt + 1'b1;
  end

  always_ff @(posedge SCK_I or negedge sck_rst_n)
  begin
    if (!sck_rst_n)
      rx_shift <= '0;
    else if (PAUSE_N_I)
      rx_shift <= {rx_shift[BW-3:0], SI_I};
  end

  // Byte boundary flag kept through deselect; bit rates too fast to count
  // in the system clock, so alignment is judged here and crossed as a level
  always_ff @(posedge SCK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      byte_end <= 1'b0;
    else if (!CS_N_I && PAUSE_N_I)
      byte_end <= (bit_cnt == sesoc_pkg::BIT_LAST);
  end

  always_ff @(posedge SCK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      rx_hold <= '0;
      byte_tgl <= 1'b0;
    end
    else if (!CS_N_I && PAUSE_N_I && bit_cnt == sesoc_pkg::BIT_LAST)
    begin
      rx_hold <= {rx_shift, SI_I};
      byte_tgl <= ~byte_tgl;
    end
  end

  // ==================================================================
  // Link domain: output shifting on falling serial clock
  logic sck_n;
  logic tx_req_tgl;
  logic tx_req_s;
  logic tx_ack_tgl;
  logic [BW-1:0] tx_word;
  logic [BW-1:0] so_shift;

  assign sck_n = ~SCK_I;

  sesoc_sync #(.W(1)) u_req_sync (
    .clk_i(sck_n),
    .rst_n_i(RST_N_I),
    .d_i(tx_req_tgl),
    .q_o(tx_req_s)
  );

  // A new byte is loaded on the falling edge that follows a whole byte
  always_ff @(negedge SCK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      so_shift <= sesoc_pkg::TX_IDLE_WORD;
      tx_ack_tgl <= 1'b0;
    end
    else if (!CS_N_I && PAUSE_N_I)
    begin
      if (bit_cnt == sesoc_pkg::BIT_FIRST)
      begin
        // No word ready means the line idles high
        so_shift <= (tx_req_s != tx_ack_tgl) ? tx_word :
                    sesoc_pkg::TX_IDLE_WORD;
        tx_ack_tgl <= tx_req_s;
      end
      else
        so_shift <= {so_shift[BW-2:0], 1'b1};
    end
  end

  assign SO_O = so_shift[BW-1];
  // Driver is gated straight from the pins, no clock needed
  assign SO_OE_O = ~CS_N_I & PAUSE_N_I & OUT_EN_I;

  // ==================================================================
  // Crossing into the system clock
  logic cs_s;
  logic end_s;
  logic byte_s;
  logic ack_s;
  logic cs_q;
  logic byte_q;
  logic cs_rise;
  logic byte_evt;

  sesoc_sync #(.W(4)) u_sys_sync (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .d_i({CS_N_I, byte_end, byte_tgl, tx_ack_tgl}),
    .q_o({cs_s, end_s, byte_s, ack_s})
  );

  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      cs_q <= 1'b1;
      byte_q <= 1'b0;
    end
    else
    begin
      cs_q <= cs_s;
      byte_q <= byte_s;
    end
  end

  assign cs_rise = cs_s && !cs_q;
  assign byte_evt = byte_s != byte_q;

  // ==================================================================
  // Power-up selection gate
  logic seen_low;

  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      seen_low <= 1'b0;
    else if (!cs_s)
      seen_low <= 1'b1;
  end

  // ==================================================================
  // Frame bit and byte accounting
  logic frame_bytes;
  logic aligned;

  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      frame_bytes <= 1'b0;
    else if (cs_q)
      frame_bytes <= 1'b0;
    else if (byte_evt)
      frame_bytes <= 1'b1;
  end

  // Any rise off a byte boundary cancels the write
  assign aligned = frame_bytes && end_s;

  // ==================================================================
  // Received byte stream through the FIFO
  sesoc_stream_if #(.W(BW)) fifo_in ();
  sesoc_stream_if #(.W(BW)) fifo_out ();

  assign fifo_in.data = rx_hold;
  // A byte arriving while full is lost; RX_ROOM_O warns the consumer
  assign fifo_in.valid = byte_evt && seen_low;
  assign RX_ROOM_O = fifo_in.ready;
  assign RX_DATA_O = fifo_out.data;
  assign RX_VALID_O = fifo_out.valid;
  assign fifo_out.ready = RX_READY_I;

  sesoc_fifo #(
    .W(BW),
    .DEPTH(sesoc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .in_if(fifo_in.snk),
    .out_if(fifo_out.src)
  );

  // ==================================================================
  // Outgoing word holding register
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      tx_word <= sesoc_pkg::TX_IDLE_WORD;
      tx_req_tgl <= 1'b0;
    end
    else if (TX_VALID_I && TX_READY_O)
    begin
      tx_word <= TX_DATA_I;
      tx_req_tgl <= ~tx_req_tgl;
    end
  end

  assign TX_READY_O = (tx_req_tgl == ack_s);

  // ==================================================================
  // Select state and write cycle
  sesoc_pkg::sesoc_state_t state;
  sesoc_pkg::sesoc_state_t next_state;
  logic [TW-1:0] timer;
  logic launch;
  logic timer_done;

  assign launch = cs_rise && seen_low && WR_ARM_I && aligned &&
                  state != sesoc_pkg::SESOC_PROGRAM;
  assign timer_done = (timer == '0);

  always_comb
  begin
    next_state = state;
    case (state)
      sesoc_pkg::SESOC_STANDBY:
        if (!cs_s && seen_low)
          next_state = sesoc_pkg::SESOC_ACTIVE;
      sesoc_pkg::SESOC_ACTIVE:
        if (launch)
          next_state = sesoc_pkg::SESOC_PROGRAM;
        else if (cs_s)
          next_state = sesoc_pkg::SESOC_STANDBY;
      sesoc_pkg::SESOC_PROGRAM:
        // Select is ignored until the cycle has run out
        if (timer_done)
          next_state = cs_s ? sesoc_pkg::SESOC_STANDBY :
                       sesoc_pkg::SESOC_ACTIVE;
      default:
        next_state = sesoc_pkg::SESOC_STANDBY;
    endcase
  end

  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      state <= sesoc_pkg::SESOC_STANDBY;
    else
      state <= next_state;
  end

  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      timer <= '0;
    else if (launch)
      timer <= TIMER_LOAD;
    else if (state == sesoc_pkg::SESOC_PROGRAM && !timer_done)
      timer <= timer - 1'b1;
  end

  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      WR_START_O <= 1'b0;
    else
      WR_START_O <= launch;
  end

  assign BUSY_O = (state == sesoc_pkg::SESOC_PROGRAM);
  assign STANDBY_O = (state == sesoc_pkg::SESOC_STANDBY);
  assign SELECTED_O = (state == sesoc_pkg::SESOC_ACTIVE);

endmodule

// >>> sesoc_sva.sv
// Checker on the ports of the select and output control
`timescale 1ns/100ps
module sesoc_sva #(
  parameter int WR_CYCLES = 50
) (
  // Watched ports
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic SCK_I,
  input wire logic CS_N_I,
  input wire logic PAUSE_N_I,
  input wire logic OUT_EN_I,
  input wire logic SO_O,
  input wire logic SO_OE_O,
  input wire logic WR_START_O,
  input wire logic BUSY_O,
  input wire logic STANDBY_O,
  input wire logic SELECTED_O
);
  logic [19:0] bcnt;
  logic so_r;
  // ==================================================================
  // Helpers
  always_ff @(posedge CLK_I or negedge RST_N_I)
    if (!RST_N_I)
      bcnt <= 20'h0;
    else
      bcnt <= BUSY_O ? bcnt + 20'h1 : 20'h0;
  // The master samples on the rise, so SO must not move there
  always_ff @(posedge SCK_I)
    so_r <= SO_O;
  sequence s_launch;
    WR_START_O ##1 (BUSY_O && !WR_START_O) [*4];
  endsequence
  // ==================================================================
  // Assertions
  a_oe_desel: assert property (
    @(posedge CLK_I) disable iff (!RST_N_I) CS_N_I |-> !SO_OE_O)
    else $error("output driven while deselected");
  a_oe_pause: assert property (
    @(posedge CLK_I) disable iff (!RST_N_I) !PAUSE_N_I |-> !SO_OE_O)
    else $error("output driven while paused");
  a_oe_sel: assert property (
    @(posedge CLK_I) disable iff (!RST_N_I)
    !CS_N_I && PAUSE_N_I && OUT_EN_I |-> SO_OE_O)
    else $error("output not driven while selected");
  a_so_hold: assert property (
    @(negedge SCK_I) disable iff (!RST_N_I) !CS_N_I |-> SO_O == so_r)
    else $error("output moved on rising clock");
  a_start_rise: assert property (
    @(posedge CLK_I) disable iff (!RST_N_I) WR_START_O |-> $rose(BUSY_O))
    else $error("write launched while busy");
  a_launch_seq: assert property (
    @(posedge CLK_I) disable iff (!RST_N_I) $rose(BUSY_O) |-> s_launch)
    else $error("launch pulse or busy malformed");
  a_start_cs: assert property (
    @(posedge CLK_I) disable iff (!RST_N_I) WR_START_O |-> $past(CS_N_I, 2))
    else $error("write launched without deselect");
  a_busy_len: assert property (
    @(posedge CLK_I) disable iff (!RST_N_I)
    $fell(BUSY_O) |-> bcnt == WR_CYCLES)
    else $error("write cycle length wrong");
  a_busy_mode: assert property (
    @(posedge CLK_I) disable iff (!RST_N_I)
    BUSY_O |-> !STANDBY_O && !SELECTED_O)
    else $error("mode changed during write cycle");
  a_end_mode: assert property (
    @(posedge CLK_I) disable iff (!RST_N_I)
    $fell(BUSY_O) && $past(CS_N_I, 4) == CS_N_I |-> STANDBY_O == CS_N_I)
    else $error("wrong mode after write cycle");
endmodule

bind sesoc_top sesoc_sva #(.WR_CYCLES(WR_CYCLES)) sesoc_sva_inst (
  .CLK_I(CLK_I), .RST_N_I(RST_N_I), .SCK_I(SCK_I), .CS_N_I(CS_N_I),
  .PAUSE_N_I(PAUSE_N_I), .OUT_EN_I(OUT_EN_I), .SO_O(SO_O),
  .SO_OE_O(SO_OE_O), .WR_START_O(WR_START_O), .BUSY_O(BUSY_O),
  .STANDBY_O(STANDBY_O), .SELECTED_O(SELECTED_O));

// >>> sesoc_master.sv
// Serial bus master model driving the link pins
`timescale 1ns/100ps
module sesoc_master (
  // Link pins
  output logic sck_o,
  output logic cs_n_o,
  output logic si_o,
  output logic pause_n_o,
  input wire logic so_i,
  input wire logic so_oe_i
);
  initial
  begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b0;
    pause_n_o = 1'b1;
  end
  // Clock stands low outside frames; edges only after select settles
  task automatic frame(input logic on);
    cs_n_o = ~on;
    #40;
  endtask
  // Most significant bit first; SI shows garbage once its hold is over
  task automatic xfer(input logic [7:0] tx, input int nb,
                      output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - nb; i--)
    begin
      si_o = tx[i];
      #2 sck_o = 1'b1;
      rx[i] = so_oe_i ? so_i : 1'bx;
      #3 sck_o = 1'b0;
      #1 si_o = ~tx[i];
    end
  endtask
  // Pause mid-byte while the shared clock keeps running
  task automatic hold();
    pause_n_o = 1'b0;
    repeat (3)
    begin
      #3 sck_o = 1'b1;
      #3 sck_o = 1'b0;
    end
    #3 pause_n_o = 1'b1;
    #3;
  endtask
endmodule

// >>> sesoc_top_bench.sv
// Self-checking bench of the select and output control
`timescale 1ns/100ps
module sesoc_top_bench;
  localparam int WRC = 50;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic rx_rdy = 1'b0;
  logic [7:0] tx_d = 8'h00;
  logic tx_vld = 1'b0;
  logic wr_arm = 1'b0;
  logic out_en = 1'b1;
  int st_cnt = 0;
  int busy_cyc = 0;
  logic sck, cs_n, si, pause_n, so, so_oe, rx_vld, room, tx_rdy;
  logic wr_st, busy, stby, sel;
  logic [7:0] rx_d, got, b;
  int failures = 0;
  int check_count = 0;
  int cyc = 0;
  int n, seen;
  int rx_q[$];
  int so_q[$];
  always #4 clk = ~clk;
  sesoc_top #(.WR_CYCLES(WRC)) sesoc_top_inst (
    .CLK_I(clk), .RST_N_I(rst_n), .SCK_I(sck), .CS_N_I(cs_n), .SI_I(si),
    .PAUSE_N_I(pause_n), .SO_O(so), .SO_OE_O(so_oe), .RX_DATA_O(rx_d),
    .RX_VALID_O(rx_vld), .RX_READY_I(rx_rdy), .RX_ROOM_O(room),
    .TX_DATA_I(tx_d), .TX_VALID_I(tx_vld), .TX_READY_O(tx_rdy),
    .OUT_EN_I(out_en), .WR_ARM_I(wr_arm), .WR_START_O(wr_st), .BUSY_O(busy),
    .STANDBY_O(stby), .SELECTED_O(sel));
  sesoc_master sesoc_master_inst (.sck_o(sck), .cs_n_o(cs_n), .si_o(si),
    .pause_n_o(pause_n), .so_i(so), .so_oe_i(so_oe));
  // ==================================================================
  // Tasks
  task automatic check(input logic [7:0] sv, input logic [7:0] ev);
    check_count++;
    if (sv !== ev)
    begin
      failures++;
      $display("MISMATCH %0t seen %h expected %h", $time, sv, ev);
    end
  endtask
  task automatic stop_test();
    if (failures == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  // One byte each way; an offered word shows on SO in the next byte
  task automatic step(input logic offer);
    b = 8'($urandom);
    if (offer)
    begin
      for (n = 0; tx_rdy !== 1'b1 && n < 50; n++)
        tick();
      tx_d = 8'($urandom);
      tx_vld = 1'b1;
      tick();
      tx_vld = 1'b0;
    end
    #($urandom_range(7));
    sesoc_master_inst.xfer(b, 8, got);
    if (so_q.size() > 0)
      check(got, 8'(so_q.pop_front()));
    so_q.push_back(offer ? int'(tx_d) : 255);
    if (rx_q.size() < 16)
      rx_q.push_back(int'(b));
    repeat (10)
      tick();
  endtask
  task automatic drain();
    while (rx_q.size() > 0)
    begin
      for (n = 0; rx_vld !== 1'b1 && n < 50; n++)
        tick();
      check(rx_d, 8'(rx_q.pop_front()));
      rx_rdy = 1'b1;
      tick();
      rx_rdy = 1'b0;
    end
    check(8'(rx_vld), 8'h00);
  endtask
  // Long hangs end the run through the same report
  always @(posedge clk)
  begin
    cyc++;
    st_cnt += int'(wr_st === 1'b1);
    busy_cyc += int'(busy === 1'b1);
    if (cyc == 20000)
    begin
      failures++;
      stop_test();
    end
  end
  // ==================================================================
  // Scenarios
  initial
  begin
    n = $urandom(33595);
    repeat (12)
      tick();
    rst_n = 1'b1;
    check(8'({stby, sel, busy, wr_st, rx_vld, room, tx_rdy}), 8'h43);
    // Overfill the buffer with the reader stalled, one word withheld
    sesoc_master_inst.frame(1'b1);
    for (int k = 0; k < 18; k++)
      step(k != 9);
    check(8'(room), 8'h00);
    sesoc_master_inst.frame(1'b0);
    so_q.delete();
    drain();
    // Partial byte lost at deselect, then a paused byte survives
    sesoc_master_inst.frame(1'b1);
    sesoc_master_inst.xfer(8'($urandom), 5, got);
    sesoc_master_inst.frame(1'b0);
    sesoc_master_inst.frame(1'b1);
    step(1'b1);
    b = 8'($urandom);
    sesoc_master_inst.xfer(b, 4, got);
    sesoc_master_inst.hold();
    sesoc_master_inst.xfer(b << 4, 4, got);
    rx_q.push_back(int'(b));
    repeat (10)
      tick();
    sesoc_master_inst.frame(1'b0);
    so_q.delete();
    drain();
    // Write launch; end the cycle once deselected and once selected
    wr_arm = 1'b1;
    for (int m = 0; m < 2; m++)
    begin
      sesoc_master_inst.frame(1'b1);
      step(1'b1);
      seen = st_cnt;
      n = busy_cyc;
      sesoc_master_inst.frame(1'b0);
      for (int w = 0; busy !== 1'b1 && w < 10; w++)
        tick();
      check(8'(st_cnt - seen), 8'h01);
      fork
        begin
          sesoc_master_inst.frame(1'b1);
          if (m == 0)
            sesoc_master_inst.frame(1'b0);
        end
        for (int w = 0; busy === 1'b1 && w < 200; w++)
          tick();
      join
      check(8'(busy_cyc - n), 8'(WRC));
      check(8'(st_cnt - seen), 8'h01);
      check(8'({stby, sel}), m == 0 ? 8'h02 : 8'h01);
      so_q.delete();
    end
    // A rise in mid-byte must not launch a write
    step(1'b1);
    out_en = 1'b0;
    tick();
    check(8'(so_oe), 8'h00);
    out_en = 1'b1;
    tick();
    check(8'(so_oe), 8'h01);
    sesoc_master_inst.xfer(8'($urandom), 4, got);
    seen = st_cnt;
    sesoc_master_inst.frame(1'b0);
    repeat (10)
      tick();
    check(8'(st_cnt - seen), 8'h00);
    drain();
    stop_test();
  end
endmodule
